// ### rtl/tcr_pkg.sv
package tcr_pkg;
	// ------------------------------------------------------------
	// register command bytes
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_DEVICE_CONFIGURATION = 8'h03;
	localparam logic [7:0] ADDR_EVENT_INTERRUPT_MASK = 8'h04;
	localparam logic [7:0] ADDR_LOCAL_HIGH_LIMIT = 8'h05;
	localparam logic [7:0] ADDR_LOCAL_LOW_LIMIT = 8'h06;
	localparam logic [7:0] ADDR_REMOTE_HIGH_LIMIT_UPPER = 8'h07;
	// ------------------------------------------------------------
	// power-up values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DEVICE_CONFIGURATION = 8'h80;
	localparam logic [7:0] RST_EVENT_INTERRUPT_MASK = 8'h07;
	localparam logic [7:0] RST_LOCAL_HIGH_LIMIT = 8'h3c;
	localparam logic [7:0] RST_LOCAL_LOW_LIMIT = 8'h00;
	localparam logic [7:0] RST_REMOTE_HIGH_LIMIT_UPPER = 8'h50;
	// ------------------------------------------------------------
	// configuration field positions
	// ------------------------------------------------------------
	localparam int CFG_IRQ_ENABLE_BIT = 7;
	localparam int CFG_POWER_DOWN_BIT = 6;
	localparam int CFG_QUEUE_LSB = 4;
	localparam int CFG_WIDTH_LSB = 2;
	localparam int CFG_RESERVED_BIT = 1;
	localparam int CFG_WARM_RESET_BIT = 0;
	// bits that read back (reserved and write-only read zero)
	localparam logic [7:0] CFG_READ_MASK = 8'hfc;
	// mask bit of the local over-temperature source
	localparam int MASK_LOCAL_OVERHEAT_BIT = 0;
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic irq_global_enable;
		logic power_down_select;
		logic [1:0] fault_queue_depth;
		logic [1:0] adc_bit_width;
	} tcr_cfg_s;
	// one-cycle queue purge requests
	typedef struct packed {
		logic all;
		logic local_high;
		logic local_low;
		logic remote_high;
	} tcr_purge_s;
	typedef enum logic [1:0] {
		TCR_DEPTH_1,
		TCR_DEPTH_2,
		TCR_DEPTH_4,
		TCR_DEPTH_6
	} tcr_depth_e;
endpackage

// ### rtl/tcr_reg8.sv
// 8-bit storage cell with a power-up value and a warm-reset return
module tcr_reg8 #(
	parameter logic [7:0] INIT = 8'h00
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// control
	input wire logic warm_in,
	input wire logic load_in,
	input wire logic [7:0] data_in,
	// stored value
	output logic [7:0] value_out
);
	logic [7:0] next_value; // value after this edge

	// warm reset beats a simultaneous load
	always_comb begin
		next_value = value_out;
		if (warm_in) begin
			next_value = INIT;
		end else if (load_in) begin
			next_value = data_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			value_out <= INIT;
		end else begin
			value_out <= next_value;
		end
	end
endmodule

// ### rtl/tcr_regs.sv
// Behaviour
// - config bit 6 selects shutdown
// - queue depth codes give 1,2,4,6
// - width codes select 9 to 12 bits
// - config bit 0 one triggers warm reset
// - config powers up as 0x80
// - config write purges queues, restarts conversion
// - mask bits enable eight event sources
// - mask powers up as 0x07
// - local high limit, power-up 0x3c
// - local low limit, power-up zero
// - remote high upper byte, power-up 0x50
// - limits are two's complement degrees
// - limit write purges its own queue
// - reboot lockout blocks the warm reset of config writes
// - sleep lockout blocks shutdown entry
// - overheat lock forces mask bit 0 and enable
// - status mirrors mask; read clears status
module tcr_regs (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// register access port (same clock domain)
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [7:0] cmd_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	// lock bits from the security register
	input wire logic local_overheat_lock_in,
	input wire logic sleep_lockout_in,
	input wire logic reboot_lockout_in,
	// status flags and the read that clears them
	input wire logic [7:0] status_in,
	input wire logic status_read_in,
	// configuration to converter and comparators
	output tcr_pkg::tcr_cfg_s cfg_out,
	output logic [2:0] queue_length_out,
	output logic [3:0] adc_bits_out,
	output logic conversion_restart_out,
	output tcr_pkg::tcr_purge_s purge_out,
	output logic warm_reset_out,
	// thresholds and mask
	output logic [7:0] event_interrupt_mask_out,
	output logic signed [7:0] local_high_limit_out,
	output logic signed [7:0] local_low_limit_out,
	output logic signed [7:0] remote_high_limit_upper_out,
	// interrupt request, active level high
	output logic irq_out
);
	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// write strobe for one command byte
	function automatic logic hit(input logic [7:0] cmd,
			input logic [7:0] addr, input logic en);
		hit = en && (cmd == addr);
	endfunction

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0] device_configuration; // stored config byte
	logic [7:0] mask_raw; // mask as last written
	logic warm; // one-cycle warm reset pulse
	logic cfg_wr; // config write strobe
	logic mask_wr; // mask write strobe
	logic [7:0] cfg_wdata; // config byte to store
	logic [7:0] limit_local_high; // raw storage outputs
	logic [7:0] limit_local_low;
	logic [7:0] limit_remote_high;
	logic next_warm;
	logic next_restart;
	tcr_pkg::tcr_purge_s next_purge;
	logic [7:0] next_rd_data;
	logic next_rd_valid;
	logic next_irq;

	assign cfg_wr = hit(cmd_in, tcr_pkg::ADDR_DEVICE_CONFIGURATION,
		wr_en_in);
	assign mask_wr = hit(cmd_in, tcr_pkg::ADDR_EVENT_INTERRUPT_MASK,
		wr_en_in);

	// shutdown may not be entered under lockout; warm-reset bit and
	// reserved bit are never stored (host writes zero to the reserved bit anyway)
	always_comb begin
		cfg_wdata = wr_data_in & tcr_pkg::CFG_READ_MASK;
		if (sleep_lockout_in) begin
			cfg_wdata[tcr_pkg::CFG_POWER_DOWN_BIT] = 1'b0;
		end
	end

	tcr_reg8 #(.INIT(tcr_pkg::RST_DEVICE_CONFIGURATION)) u_cfg (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.warm_in(warm),
		.load_in(cfg_wr),
		.data_in(cfg_wdata),
		.value_out(device_configuration)
	);
	tcr_reg8 #(.INIT(tcr_pkg::RST_EVENT_INTERRUPT_MASK)) u_mask (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.warm_in(warm),
		.load_in(mask_wr),
		.data_in(wr_data_in),
		.value_out(mask_raw)
	);
	tcr_reg8 #(.INIT(tcr_pkg::RST_LOCAL_HIGH_LIMIT)) u_lhi (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.warm_in(warm),
		.load_in(hit(cmd_in, tcr_pkg::ADDR_LOCAL_HIGH_LIMIT, wr_en_in)),
		.data_in(wr_data_in),
		.value_out(limit_local_high)
	);
	tcr_reg8 #(.INIT(tcr_pkg::RST_LOCAL_LOW_LIMIT)) u_llo (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.warm_in(warm),
		.load_in(hit(cmd_in, tcr_pkg::ADDR_LOCAL_LOW_LIMIT, wr_en_in)),
		.data_in(wr_data_in),
		.value_out(limit_local_low)
	);
	tcr_reg8 #(.INIT(tcr_pkg::RST_REMOTE_HIGH_LIMIT_UPPER)) u_rhi (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.warm_in(warm),
		.load_in(hit(cmd_in, tcr_pkg::ADDR_REMOTE_HIGH_LIMIT_UPPER,
			wr_en_in)),
		.data_in(wr_data_in),
		.value_out(limit_remote_high)
	);

	// ------------------------------------------------------------
	// effective configuration
	// ------------------------------------------------------------
	// locks act on the live value, so setting one takes effect at once
	always_comb begin
		cfg_out.irq_global_enable =
			device_configuration[tcr_pkg::CFG_IRQ_ENABLE_BIT] |
			local_overheat_lock_in;
		cfg_out.power_down_select =
			device_configuration[tcr_pkg::CFG_POWER_DOWN_BIT] &
			~sleep_lockout_in;
		cfg_out.fault_queue_depth =
			device_configuration[tcr_pkg::CFG_QUEUE_LSB +: 2];
		cfg_out.adc_bit_width =
			device_configuration[tcr_pkg::CFG_WIDTH_LSB +: 2];
		event_interrupt_mask_out = mask_raw;
		event_interrupt_mask_out[tcr_pkg::MASK_LOCAL_OVERHEAT_BIT] =
			mask_raw[tcr_pkg::MASK_LOCAL_OVERHEAT_BIT] |
			local_overheat_lock_in;
	end

	// queue length decode
	always_comb begin
		case (tcr_pkg::tcr_depth_e'(cfg_out.fault_queue_depth))
			tcr_pkg::TCR_DEPTH_1: queue_length_out = 3'h1;
			tcr_pkg::TCR_DEPTH_2: queue_length_out = 3'h2;
			tcr_pkg::TCR_DEPTH_4: queue_length_out = 3'h4;
			default: queue_length_out = 3'h6;
		endcase
	end

	// converter precision: code plus nine
	assign adc_bits_out = 4'h9 + {2'h0, cfg_out.adc_bit_width};

	// signed whole-degree views of the limits
	assign local_high_limit_out = limit_local_high;
	assign local_low_limit_out = limit_local_low;
	assign remote_high_limit_upper_out = limit_remote_high;

	// ------------------------------------------------------------
	// write side effects, read data and interrupt
	// ------------------------------------------------------------
	// all side effects are one-cycle pulses the edge after the write
	always_comb begin
		next_warm = cfg_wr &&
			wr_data_in[tcr_pkg::CFG_WARM_RESET_BIT] &&
			!reboot_lockout_in;
		next_restart = cfg_wr;
		next_purge.all = cfg_wr;
		next_purge.local_high =
			hit(cmd_in, tcr_pkg::ADDR_LOCAL_HIGH_LIMIT, wr_en_in);
		next_purge.local_low =
			hit(cmd_in, tcr_pkg::ADDR_LOCAL_LOW_LIMIT, wr_en_in);
		next_purge.remote_high = hit(cmd_in,
			tcr_pkg::ADDR_REMOTE_HIGH_LIMIT_UPPER, wr_en_in);
		next_rd_valid = rd_en_in;
		next_rd_data = rd_data_out;
		if (rd_en_in) begin
			// unmapped command bytes read zero
			if (cmd_in == tcr_pkg::ADDR_DEVICE_CONFIGURATION) begin
				next_rd_data = {cfg_out.irq_global_enable,
					cfg_out.power_down_select,
					cfg_out.fault_queue_depth,
					cfg_out.adc_bit_width, 2'h0};
			end else if (cmd_in == tcr_pkg::ADDR_EVENT_INTERRUPT_MASK) begin
				next_rd_data = event_interrupt_mask_out;
			end else if (cmd_in == tcr_pkg::ADDR_LOCAL_HIGH_LIMIT) begin
				next_rd_data = limit_local_high;
			end else if (cmd_in == tcr_pkg::ADDR_LOCAL_LOW_LIMIT) begin
				next_rd_data = limit_local_low;
			end else if (cmd_in == tcr_pkg::ADDR_REMOTE_HIGH_LIMIT_UPPER)
					begin
				next_rd_data = limit_remote_high;
			end else begin
				next_rd_data = 8'h00;
			end
		end
		// status bit n pairs with mask bit n; a status read clears the
		// flags next cycle, so the line drops with them
		next_irq = cfg_out.irq_global_enable && !status_read_in &&
			|(status_in & event_interrupt_mask_out);
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			warm <= 1'b0;
			conversion_restart_out <= 1'b0;
			purge_out <= '0;
			rd_data_out <= 8'h00;
			rd_valid_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			warm <= next_warm;
			conversion_restart_out <= next_restart;
			purge_out <= next_purge;
			rd_data_out <= next_rd_data;
			rd_valid_out <= next_rd_valid;
			irq_out <= next_irq;
		end
	end

	assign warm_reset_out = warm;
endmodule

// ### testbench/tcr_regs_checker.sv
module tcr_regs_checker (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// register access
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [7:0] cmd_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [7:0] rd_data_out,
	input wire logic rd_valid_out,
	// locks and status
	input wire logic local_overheat_lock_in,
	input wire logic sleep_lockout_in,
	input wire logic reboot_lockout_in,
	input wire logic [7:0] status_in,
	input wire logic status_read_in,
	// outputs watched
	input wire tcr_pkg::tcr_cfg_s cfg_out,
	input wire logic [2:0] queue_length_out,
	input wire logic [3:0] adc_bits_out,
	input wire logic conversion_restart_out,
	input wire tcr_pkg::tcr_purge_s purge_out,
	input wire logic warm_reset_out,
	input wire logic [7:0] event_interrupt_mask_out,
	input wire logic signed [7:0] local_high_limit_out,
	input wire logic irq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	logic cfg_wr; // config write taken this edge
	logic cause; // an enabled, unmasked event is pending
	assign cfg_wr = wr_en_in && cmd_in == 8'h03;
	assign cause = cfg_out.irq_global_enable
		&& |(status_in & event_interrupt_mask_out);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_read_answer: assert property (rd_en_in |=> rd_valid_out)
		else $error("read not answered next cycle");
	a_cfg_restart: assert property (
		cfg_wr |=> conversion_restart_out && purge_out.all)
		else $error("config write gave no restart or purge");
	a_limit_purge: assert property (
		wr_en_in && cmd_in == 8'h05 |=> purge_out.local_high)
		else $error("limit write did not purge its queue");
	a_low_purge: assert property (
		wr_en_in && cmd_in == 8'h06 |=> purge_out.local_low)
		else $error("low limit write did not purge its queue");
	a_rhi_purge: assert property (
		wr_en_in && cmd_in == 8'h07 |=> purge_out.remote_high)
		else $error("remote limit write did not purge its queue");
	a_warm_pulse: assert property (
		cfg_wr && wr_data_in[0] && !reboot_lockout_in |=> warm_reset_out)
		else $error("warm reset not started");
	a_warm_locked: assert property (
		cfg_wr && reboot_lockout_in |=> !warm_reset_out)
		else $error("warm reset ran while locked");
	a_warm_default: assert property (
		warm_reset_out && !wr_en_in |=> local_high_limit_out == 8'sh3c
		&& event_interrupt_mask_out == 8'h07)
		else $error("warm reset left values changed");
	a_sleep_lock: assert property (
		sleep_lockout_in |-> !cfg_out.power_down_select)
		else $error("shutdown shown while locked out");
	a_overheat_lock: assert property (
		local_overheat_lock_in |-> event_interrupt_mask_out[0]
		&& cfg_out.irq_global_enable)
		else $error("overheat lock not forcing mask and enable");
	a_irq_cause: assert property (irq_out |-> $past(cause))
		else $error("irq without enabled masked event");
	a_irq_raise: assert property (
		cause && !status_read_in |=> irq_out)
		else $error("irq missing for pending event");
	a_depth_decode: assert property (queue_length_out ==
		(&cfg_out.fault_queue_depth ? 3'h6 : 3'h1 << cfg_out.fault_queue_depth))
		else $error("queue depth decode wrong");
	a_width_decode: assert property (
		adc_bits_out == 4'h9 + 4'(cfg_out.adc_bit_width))
		else $error("converter width decode wrong");
	a_cfg_reserved: assert property (
		rd_valid_out && $past(cmd_in) == 8'h03 |-> rd_data_out[1:0] == 2'h0)
		else $error("reserved config bits read nonzero");
	// main scenarios reached
	c_warm: cover property (warm_reset_out);
	c_irq: cover property (irq_out);
	c_lock: cover property (local_overheat_lock_in && irq_out);
endmodule
bind tcr_regs tcr_regs_checker tcr_regs_checker_i (.clk_sys_in, .reset_n_in,
	.wr_en_in, .rd_en_in, .cmd_in, .wr_data_in, .rd_data_out, .rd_valid_out,
	.local_overheat_lock_in, .sleep_lockout_in, .reboot_lockout_in,
	.status_in, .status_read_in, .cfg_out, .queue_length_out, .adc_bits_out,
	.conversion_restart_out, .purge_out, .warm_reset_out,
	.event_interrupt_mask_out, .local_high_limit_out, .irq_out);

// ### testbench/tcr_host.sv
// host side of the management bus, single byte transfers
module tcr_host (
	// clock and answer
	input wire logic clk_sys_in,
	input wire logic rd_valid_in,
	input wire logic [7:0] rd_data_in,
	// request
	output logic wr_en_out,
	output logic rd_en_out,
	output logic [7:0] cmd_out,
	output logic [7:0] wr_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		cmd_out = 8'h00;
		wr_data_out = 8'h00;
	end
	// one-cycle write; data scrambled once released
	task automatic wr_byte(input logic [7:0] cmd, input logic [7:0] data);
		@(negedge clk_sys_in);
		cmd_out = cmd;
		wr_data_out = (cmd == 8'h03) ? data & 8'hfd : data;
		wr_en_out = 1'b1;
		@(negedge clk_sys_in);
		wr_en_out = 1'b0;
		wr_data_out = ~wr_data_out;
	endtask
	// no answer yields a corrupted byte so the caller sees it
	task automatic rd_byte(input logic [7:0] cmd, output logic [7:0] data);
		@(negedge clk_sys_in);
		cmd_out = cmd;
		rd_en_out = 1'b1;
		@(negedge clk_sys_in);
		rd_en_out = 1'b0;
		data = rd_valid_in ? rd_data_in : ~rd_data_in;
	endtask
endmodule

// ### testbench/tcr_regs_tb.sv
module tcr_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in, reset_n_in, wr_en_in, rd_en_in, rd_valid_out, irq_out;
	logic local_overheat_lock_in, sleep_lockout_in, reboot_lockout_in;
	logic status_read_in;
	logic [7:0] cmd_in, wr_data_in, rd_data_out, status_in;
	logic [7:0] event_interrupt_mask_out;
	logic signed [7:0] local_high_limit_out;
	logic signed [7:0] local_low_limit_out, remote_high_limit_upper_out;
	logic [2:0] queue_length_out;
	logic [3:0] adc_bits_out;
	tcr_pkg::tcr_cfg_s cfg_out;
	int fails = 0;
	int n_checks = 0;
	tcr_regs tcr_regs_i (.clk_sys_in, .reset_n_in, .wr_en_in, .rd_en_in,
		.cmd_in, .wr_data_in, .rd_data_out, .rd_valid_out,
		.local_overheat_lock_in, .sleep_lockout_in, .reboot_lockout_in,
		.status_in, .status_read_in, .cfg_out, .queue_length_out,
		.adc_bits_out, .conversion_restart_out(), .purge_out(),
		.warm_reset_out(), .event_interrupt_mask_out, .local_high_limit_out,
		.local_low_limit_out, .remote_high_limit_upper_out, .irq_out);
	tcr_host tcr_host_i (.clk_sys_in, .rd_valid_in(rd_valid_out),
		.rd_data_in(rd_data_out), .wr_en_out(wr_en_in), .rd_en_out(rd_en_in),
		.cmd_out(cmd_in), .wr_data_out(wr_data_in));
	// ------------------------------------------------------------
	// shared checks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
		logic [7:0] d;
		tcr_host_i.rd_byte(cmd, d);
		chk(d, exp);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_defaults();
		rd_chk(8'h03, 8'h80);
		rd_chk(8'h04, 8'h07);
		rd_chk(8'h05, 8'h3c);
		rd_chk(8'h06, 8'h00);
		rd_chk(8'h07, 8'h50);
		rd_chk(8'h1f, 8'h00); // unmapped place reads zero
		$display("defaults done");
	endtask
	task automatic t_fields();
		logic [7:0] dep [4] = '{8'h1, 8'h2, 8'h4, 8'h6};
		for (int i = 0; i < 4; i++) begin
			tcr_host_i.wr_byte(8'h03, {2'b01, 2'(i), 2'(3 - i), 2'b00});
			chk(8'(queue_length_out), dep[i]);
			chk(8'(adc_bits_out), 8'h0c - 8'(i));
			chk(8'(cfg_out.power_down_select), 8'h01);
		end
		sleep_lockout_in = 1'b1;
		wait_n(1);
		chk(8'(cfg_out.power_down_select), 8'h00);
		tcr_host_i.wr_byte(8'h03, 8'hc0);
		// release first: readback must show the bit was never stored
		sleep_lockout_in = 1'b0;
		rd_chk(8'h03, 8'h80);
		$display("fields done");
	endtask
	task automatic t_limits();
		logic [7:0] v [4] = '{8'ha5, 8'hf6, 8'h81, 8'h7f};
		for (int i = 0; i < 4; i++) begin
			tcr_host_i.wr_byte(8'h04 + 8'(i), v[i]);
			rd_chk(8'h04 + 8'(i), v[i]);
		end
		chk(8'(local_high_limit_out + 8'sd10), 8'h00);
		chk(local_low_limit_out, 8'h81);
		chk(remote_high_limit_upper_out, 8'h7f);
		$display("limits done");
	endtask
	task automatic t_warm();
		reboot_lockout_in = 1'b1;
		tcr_host_i.wr_byte(8'h03, 8'h01);
		wait_n(2);
		rd_chk(8'h03, 8'h00);
		rd_chk(8'h05, 8'hf6);
		reboot_lockout_in = 1'b0;
		tcr_host_i.wr_byte(8'h03, 8'h81);
		wait_n(2);
		rd_chk(8'h03, 8'h80);
		rd_chk(8'h04, 8'h07);
		rd_chk(8'h05, 8'h3c);
		$display("warm reset done");
	endtask
	task automatic t_irq();
		status_in = 8'h40;
		tcr_host_i.wr_byte(8'h04, 8'h40);
		wait_n(2);
		chk(8'(irq_out), 8'h01);
		// global enable off must hold the line low despite the event
		tcr_host_i.wr_byte(8'h03, 8'h00);
		wait_n(2);
		chk(8'(irq_out), 8'h00);
		tcr_host_i.wr_byte(8'h03, 8'h80);
		tcr_host_i.wr_byte(8'h04, 8'hbf);
		wait_n(2);
		chk(8'(irq_out), 8'h00);
		local_overheat_lock_in = 1'b1;
		status_in = 8'h01;
		tcr_host_i.wr_byte(8'h03, 8'h00);
		tcr_host_i.wr_byte(8'h04, 8'h00);
		wait_n(2);
		chk(event_interrupt_mask_out, 8'h01);
		chk(8'(irq_out), 8'h01);
		status_read_in = 1'b1;
		wait_n(1);
		status_read_in = 1'b0;
		chk(8'(irq_out), 8'h00);
		local_overheat_lock_in = 1'b0;
		status_in = 8'h00;
		$display("interrupt done");
	endtask
	// ------------------------------------------------------------
	// closing, clock, sequence and watchdog
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		reset_n_in = 1'b0;
		local_overheat_lock_in = 1'b0;
		sleep_lockout_in = 1'b0;
		reboot_lockout_in = 1'b0;
		status_in = 8'h00;
		status_read_in = 1'b0;
		wait_n(16);
		reset_n_in = 1'b1;
		t_defaults();
		t_fields();
		t_limits();
		t_warm();
		t_irq();
		complete_run();
	end
	// whole run needs about 100 cycles; allow far more
	initial begin
		#(100 * 2000);
		fails++;
		complete_run();
	end
endmodule
